//--- readback_pkg.sv
// Shared constants for the status and converter readback block
package readback_pkg;

  // ==========================================================================
  // Register bus map (byte addresses)
  localparam logic [7:0] OFS_CMP_WORD = 8'h00;
  localparam logic [7:0] OFS_ALARM_WORD = 8'h04;
  localparam logic [7:0] OFS_MEAS_CTRL = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_DAC_SELECT = 8'h14;
  localparam logic [7:0] OFS_DAC_WRITE = 8'h18;
  localparam logic [7:0] OFS_CHAN_WORD0 = 8'h20;

  // ==========================================================================
  // Word layout
  localparam int WORD_W = 24;
  localparam int TYPE_HI_POS = 23;
  localparam int TYPE_LO_POS = 22;
  localparam int CMP_FLAGS_LSB = 14;
  localparam int OT_LATCHED_POS = 21;
  localparam int OT_LIVE_POS = 20;
  localparam int GUARD_FLAGS_LSB = 12;
  localparam int CLAMP_FLAGS_LSB = 4;
  localparam int DAC_SEL_LSB = 16;
  localparam int CHAN_OT_LATCHED_POS = 6;
  localparam int CHAN_OT_LIVE_POS = 5;
  localparam int CLR_OT_POS = 6;
  localparam int CLR_GC_POS = 5;
  localparam int CHANNELS = 4;
  localparam int FLAG_W = 9;

  // ==========================================================================
  // Word type codes
  localparam logic [1:0] TYPE_CMP = 2'h1;
  localparam logic [1:0] TYPE_ALARM = 2'h3;
  localparam logic [1:0] TYPE_GAIN = 2'h1;
  localparam logic [1:0] TYPE_OFFSET = 2'h2;
  localparam logic [1:0] TYPE_CODE = 2'h3;

  // ==========================================================================
  // Values after reset
  localparam logic [15:0] GAIN_RESET = 16'hFFFF;
  localparam logic [15:0] OFFSET_RESET = 16'h8000;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 9'h1FF;
  localparam logic [7:0] CMP_SYNC_RESET = 8'h00;
  localparam logic [FLAG_W-1:0] IRQ_RESET = 9'h000;

endpackage

//--- fault_flags_if.sv
// Live and latched fault flags passed between the top and the latch bank
`timescale 1ns/1ps
interface fault_flags_if #(
  parameter int N = 9
);
  logic [N-1:0] live;
  logic [N-1:0] clear;
  logic [N-1:0] latched;
  logic [N-1:0] rise;

  modport latch_side (input live, input clear, output latched, output rise);
  modport user_side (output live, output clear, input latched, input rise);
endinterface

//--- sync_bank.sv
// Two flip-flop synchroniser for a bank of pin inputs
`timescale 1ns/1ps
module sync_bank #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;

  // First stage is read by the second stage only
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stage1 <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule

//--- fault_latch.sv
// Sticky fault flags with rising-edge event detection
`timescale 1ns/1ps
module fault_latch
  import readback_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Flags
  fault_flags_if.latch_side flags
);

  logic [FLAG_W-1:0] live_q;

  // A live fault in the clearing cycle keeps the flag set
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags.latched <= FLAGS_RESET;
      live_q <= FLAGS_RESET;
    end else begin
      flags.latched <= (flags.latched & ~flags.clear) | flags.live;
      live_q <= flags.live;
    end
  end

  // Reset value of one on live_q avoids a false event at reset release
  assign flags.rise = flags.live & ~live_q;

endmodule

//--- status_and_dac_readback.sv
// Comparator, alarm and converter register readback with interrupt logic
`timescale 1ns/1ps

// Notes on behaviour
// - The comparator word is read only and writes never change it.
// - Bits 21 to 14 hold a low and a high comparator flag per channel, channel 0 on top.
// - A comparator flag reads 1 when its comparator output is high and 0 when low.
// - The alarm word is read only and carries type code 11 in bits 23 and 22.
// - Each of the four channel readback words also carries the overtemperature flags.
// - Bit 21 is the latched overtemperature flag and bit 20 the live one.
// - The latched overtemperature flag stays set until a 1 is written to clear bit 6.
// - Bits 19 to 12 hold a latched then a live guard flag for channels 0 to 3.
// - Guard and clamp flags show which channel pulled the shared fault pin and if the fault remains.
// - Bits 11 to 4 hold a latched then a live clamp flag for channels 0 to 3.
// - The converter readback word is 24 bits: type, address and sixteen data bits.
// - The type field reads 01 for gain, 10 for offset and 11 for input code.
// - Bits 21 to 16 return the six-bit address of the register read back.
// - Bits 15 to 0 return the full contents of the addressed register.
// - After power-on the alarm word reads FFFFF0 and the comparator word 400000.
module status_and_dac_readback
  import readback_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DAC_SEL_W = 6,
  parameter int DAC_DATA_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Comparator outputs, one pair per channel
  input wire logic [CHANNELS-1:0] cmp_low_pin_i,
  input wire logic [CHANNELS-1:0] cmp_high_pin_i,
  // Analog fault detectors
  input wire logic overtemp_pin_i,
  input wire logic [CHANNELS-1:0] guard_fault_pin_i,
  input wire logic [CHANNELS-1:0] clamp_fault_pin_i,
  // Open-drain alarm pins
  output logic shared_fault_pin_o,
  output logic shared_fault_pin_oe_o,
  output logic overtemp_pin_o,
  output logic overtemp_pin_oe_o,
  // Interrupt
  output logic irq_o
);

  localparam int DAC_DEPTH = 1 << DAC_SEL_W;

  // ==========================================================================
  // Reset release
  // Two flops so that no register leaves reset on a metastable edge
  logic rst_meta_b;
  logic rst_b;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_b <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_b <= rst_meta_b;
    end
  end

  // ==========================================================================
  // Helper functions

  // Interleave two per-channel vectors, channel 0 in the top pair
  function automatic logic [2*CHANNELS-1:0] pair_flags(
    input logic [CHANNELS-1:0] first,
    input logic [CHANNELS-1:0] second
  );
    logic [2*CHANNELS-1:0] out;
    out = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      out[2*CHANNELS-1-2*i] = first[i];
      out[2*CHANNELS-2-2*i] = second[i];
    end
    return out;
  endfunction

  // Address decode for one byte address, used by the strobes and the read selects
  function automatic logic hit(
    input logic [ADDR_W-1:0] addr,
    input logic [7:0] ofs
  );
    return addr == ADDR_W'(ofs);
  endfunction

  // ==========================================================================
  // Pin synchronisers
  logic [2*CHANNELS-1:0] cmp_sync;
  logic [FLAG_W-1:0] fault_sync;

  // Fault order: overtemp in bit 0, guard in 4:1, clamp in 8:5, as in the interrupt bits
  wire [2*CHANNELS-1:0] cmp_pins = {cmp_high_pin_i, cmp_low_pin_i};
  wire [FLAG_W-1:0] fault_pins = {clamp_fault_pin_i, guard_fault_pin_i, overtemp_pin_i};

  // Comparators start low so the word reads 400000 after power-on
  sync_bank #(
    .WIDTH(2*CHANNELS),
    .RESET_VAL(CMP_SYNC_RESET)
  ) u_cmp_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b),
    .async_i(cmp_pins),
    .sync_o(cmp_sync)
  );

  // Faults start set so the alarm word reads FFFFF0 after power-on
  sync_bank #(
    .WIDTH(FLAG_W),
    .RESET_VAL(FLAGS_RESET)
  ) u_fault_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b),
    .async_i(fault_pins),
    .sync_o(fault_sync)
  );

  wire [CHANNELS-1:0] cmp_low = cmp_sync[CHANNELS-1:0];
  wire [CHANNELS-1:0] cmp_high = cmp_sync[2*CHANNELS-1:CHANNELS];

  // ==========================================================================
  // Register strobes
  wire wr_meas_ctrl = reg_wr_i && hit(reg_addr_i, OFS_MEAS_CTRL);
  wire wr_irq_mask = reg_wr_i && hit(reg_addr_i, OFS_IRQ_MASK);
  wire wr_dac_select = reg_wr_i && hit(reg_addr_i, OFS_DAC_SELECT);
  wire wr_dac_write = reg_wr_i && hit(reg_addr_i, OFS_DAC_WRITE);
  wire rd_irq_status = reg_rd_i && hit(reg_addr_i, OFS_IRQ_STATUS);

  // ==========================================================================
  // Latched fault flags
  fault_flags_if #(.N(FLAG_W)) faults ();

  // Bit 6 clears the overtemp flag, bit 5 every guard and clamp flag
  wire clr_overtemp = wr_meas_ctrl && reg_wdata_i[CLR_OT_POS];
  wire clr_guard_clamp = wr_meas_ctrl && reg_wdata_i[CLR_GC_POS];

  assign faults.live = fault_sync;
  assign faults.clear = {{(FLAG_W-1){clr_guard_clamp}}, clr_overtemp};

  fault_latch u_fault_latch (
    .clk_i(clk_i),
    .rst_b_i(rst_b),
    .flags(faults.latch_side)
  );

  wire ot_live = faults.live[0];
  wire ot_latched = faults.latched[0];
  wire [CHANNELS-1:0] guard_live = faults.live[CHANNELS:1];
  wire [CHANNELS-1:0] guard_latched = faults.latched[CHANNELS:1];
  wire [CHANNELS-1:0] clamp_live = faults.live[2*CHANNELS:CHANNELS+1];
  wire [CHANNELS-1:0] clamp_latched = faults.latched[2*CHANNELS:CHANNELS+1];

  // ==========================================================================
  // Readback words
  wire [WORD_W-1:0] cmp_word;
  wire [WORD_W-1:0] alarm_word;

  // Each pair puts channel 0 on top
  wire [2*CHANNELS-1:0] cmp_pairs = pair_flags(cmp_low, cmp_high);
  wire [2*CHANNELS-1:0] guard_pairs = pair_flags(guard_latched, guard_live);
  wire [2*CHANNELS-1:0] clamp_pairs = pair_flags(clamp_latched, clamp_live);

  // Synchronised pins alone feed the word, so host writes have nothing to alter
  assign cmp_word = {TYPE_CMP, cmp_pairs,
    {CMP_FLAGS_LSB{1'b0}}};

  assign alarm_word = {TYPE_ALARM, ot_latched, ot_live,
    guard_pairs,
    clamp_pairs,
    {CLAMP_FLAGS_LSB{1'b0}}};

  // Channel words carry only the temperature flags in this block
  logic [WORD_W-1:0] chan_word;
  always_comb begin
    chan_word = '0;
    chan_word[CHAN_OT_LATCHED_POS] = ot_latched;
    chan_word[CHAN_OT_LIVE_POS] = ot_live;
  end

  // Only word-aligned offsets inside the four channel slots hit
  wire [ADDR_W-1:0] chan_ofs = reg_addr_i - ADDR_W'(OFS_CHAN_WORD0);
  wire chan_hit = (reg_addr_i >= ADDR_W'(OFS_CHAN_WORD0)) &&
    (chan_ofs < ADDR_W'(4*CHANNELS)) && (chan_ofs[1:0] == 2'h0);

  // ==========================================================================
  // Converter register store
  logic [DAC_DATA_W-1:0] gain_mem [DAC_DEPTH];
  logic [DAC_DATA_W-1:0] offset_mem [DAC_DEPTH];
  logic [DAC_DATA_W-1:0] code_mem [DAC_DEPTH];
  logic [DAC_DEPTH-1:0] gain_written;
  logic [DAC_DEPTH-1:0] offset_written;
  logic [DAC_DEPTH-1:0] code_written;

  wire [1:0] dac_wr_type = reg_wdata_i[TYPE_HI_POS:TYPE_LO_POS];
  wire [DAC_SEL_W-1:0] dac_wr_sel = reg_wdata_i[DAC_SEL_LSB+DAC_SEL_W-1:DAC_SEL_LSB];
  wire [DAC_DATA_W-1:0] dac_wr_data = reg_wdata_i[DAC_DATA_W-1:0];

  // Type 00 names no register, so such a write is dropped
  wire wr_gain = wr_dac_write && dac_wr_type == TYPE_GAIN;
  wire wr_offset = wr_dac_write && dac_wr_type == TYPE_OFFSET;
  wire wr_code = wr_dac_write && dac_wr_type == TYPE_CODE;

  // Memories carry no reset; the written flags stand in for the defaults
  always_ff @(posedge clk_i) begin
    if (wr_gain) begin
      gain_mem[dac_wr_sel] <= dac_wr_data;
    end
    if (wr_offset) begin
      offset_mem[dac_wr_sel] <= dac_wr_data;
    end
    if (wr_code) begin
      code_mem[dac_wr_sel] <= dac_wr_data;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      gain_written <= '0;
      offset_written <= '0;
      code_written <= '0;
    end else if (wr_dac_write) begin
      gain_written[dac_wr_sel] <= gain_written[dac_wr_sel] | wr_gain;
      offset_written[dac_wr_sel] <= offset_written[dac_wr_sel] | wr_offset;
      code_written[dac_wr_sel] <= code_written[dac_wr_sel] | wr_code;
    end
  end

  // Readback selection: type and address of the register to return
  logic [1:0] dac_rd_type;
  logic [DAC_SEL_W-1:0] dac_rd_sel;

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      dac_rd_type <= TYPE_CODE;
      dac_rd_sel <= '0;
    end else if (wr_dac_select) begin
      dac_rd_type <= dac_wr_type;
      dac_rd_sel <= dac_wr_sel;
    end
  end

  wire [DAC_DATA_W-1:0] gain_value = gain_written[dac_rd_sel] ? gain_mem[dac_rd_sel] : GAIN_RESET;
  wire [DAC_DATA_W-1:0] offset_value = offset_written[dac_rd_sel] ? offset_mem[dac_rd_sel] : OFFSET_RESET;
  wire [DAC_DATA_W-1:0] code_value = code_written[dac_rd_sel] ? code_mem[dac_rd_sel] : CODE_RESET;

  // A selection of type 00 reads zero data
  logic [DAC_DATA_W-1:0] dac_value;
  always_comb begin
    unique case (dac_rd_type)
      TYPE_GAIN: dac_value = gain_value;
      TYPE_OFFSET: dac_value = offset_value;
      TYPE_CODE: dac_value = code_value;
      default: dac_value = '0;
    endcase
  end

  wire [WORD_W-1:0] dac_word = {dac_rd_type, dac_rd_sel, dac_value};

  // ==========================================================================
  // Interrupt status and mask
  logic [FLAG_W-1:0] irq_status;
  logic [FLAG_W-1:0] irq_mask;
  wire [FLAG_W-1:0] next_irq_status = (rd_irq_status ? '0 : irq_status) | faults.rise;

  // A fault rising in the cycle of the clearing read is kept
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      irq_status <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
    end else begin
      irq_status <= next_irq_status;
      if (wr_irq_mask) begin
        irq_mask <= reg_wdata_i[FLAG_W-1:0];
      end
    end
  end

  // Level output: any unmasked status bit holds it high
  wire [FLAG_W-1:0] irq_pending = irq_status & irq_mask;
  assign irq_o = |irq_pending;

  // ==========================================================================
  // Open-drain alarm pins, each pulled low while one of its own latched flags is set
  wire shared_fault_any = |{guard_latched, clamp_latched};

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      shared_fault_pin_oe_o <= 1'b0;
      overtemp_pin_oe_o <= 1'b0;
    end else begin
      shared_fault_pin_oe_o <= shared_fault_any;
      overtemp_pin_oe_o <= ot_latched;
    end
  end

  // Data stays low; the enables alone pull the pins
  assign shared_fault_pin_o = 1'b0;
  assign overtemp_pin_o = 1'b0;

  // ==========================================================================
  // Read data, valid only in the cycle after the read strobe
  wire sel_cmp_word = hit(reg_addr_i, OFS_CMP_WORD);
  wire sel_alarm_word = hit(reg_addr_i, OFS_ALARM_WORD);
  wire sel_irq_status = hit(reg_addr_i, OFS_IRQ_STATUS);
  wire sel_irq_mask = hit(reg_addr_i, OFS_IRQ_MASK);
  wire sel_dac_word = hit(reg_addr_i, OFS_DAC_SELECT);

  // Unmapped addresses read as zero
  logic [WORD_W-1:0] rd_word;
  always_comb begin
    rd_word = '0;
    if (sel_cmp_word) begin
      rd_word = cmp_word;
    end else if (sel_alarm_word) begin
      rd_word = alarm_word;
    end else if (sel_irq_status) begin
      rd_word = WORD_W'(irq_status);
    end else if (sel_irq_mask) begin
      rd_word = WORD_W'(irq_mask);
    end else if (sel_dac_word) begin
      rd_word = dac_word;
    end else if (chan_hit) begin
      rd_word = chan_word;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= {8'h00, rd_word};
    end else begin
      reg_rdata_o <= '0;
    end
  end

endmodule

//--- readback_properties.sv
// Port-level checks for the status and converter readback block
`timescale 1ns/1ps
module readback_properties
  import readback_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // Pins
  input wire logic [CHANNELS-1:0] cmp_low_pin_i,
  input wire logic [CHANNELS-1:0] cmp_high_pin_i,
  input wire logic overtemp_pin_i,
  input wire logic [CHANNELS-1:0] guard_fault_pin_i,
  input wire logic [CHANNELS-1:0] clamp_fault_pin_i,
  input wire logic shared_fault_pin_o,
  input wire logic shared_fault_pin_oe_o,
  input wire logic overtemp_pin_o,
  input wire logic overtemp_pin_oe_o,
  input wire logic irq_o
);
  // ==========================================================================
  // Helper logic
  // Pin checks wait until the reset synchroniser and pin synchronisers settle
  logic [3:0] warm;
  logic [8:0] mask_copy;
  logic [7:0] sel_copy;
  wire logic rd_cmp = reg_rd_i && reg_addr_i == OFS_CMP_WORD;
  wire logic rd_alarm = reg_rd_i && reg_addr_i == OFS_ALARM_WORD;
  wire logic rd_dac = reg_rd_i && reg_addr_i == OFS_DAC_SELECT;
  wire logic rd_chan = reg_rd_i && (reg_addr_i & 8'hF3) == OFS_CHAN_WORD0;
  wire logic [12:0] pins = {cmp_low_pin_i, cmp_high_pin_i, overtemp_pin_i, guard_fault_pin_i};
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      warm <= 4'h0;
      mask_copy <= 9'h000;
      sel_copy <= 8'hC0;
    end else begin
      if (warm != 4'hF) warm <= warm + 4'h1;
      if (reg_wr_i && reg_addr_i == OFS_IRQ_MASK) mask_copy <= reg_wdata_i[8:0];
      if (reg_wr_i && reg_addr_i == OFS_DAC_SELECT) sel_copy <= reg_wdata_i[23:16];
    end
  end
  function automatic logic [7:0] cmp_pack(input logic [3:0] lo, input logic [3:0] hi);
    for (int c = 0; c < 4; c++) begin
      cmp_pack[7-2*c] = lo[c];
      cmp_pack[6-2*c] = hi[c];
    end
  endfunction
  function automatic logic [23:0] live_pack(input logic ot, input logic [3:0] g, input logic [3:0] k);
    live_pack = 24'h0;
    live_pack[20] = ot;
    for (int c = 0; c < 4; c++) begin
      live_pack[18-2*c] = g[c];
      live_pack[10-2*c] = k[c];
    end
  endfunction
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_rdata_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not zero outside read answer");
  a_cmp_word_frame: assert property (rd_cmp |=> reg_rdata_o[31:22] == {8'h00, TYPE_CMP} && reg_rdata_o[13:0] == 14'h0)
    else $error("comparator word frame wrong");
  a_alarm_word_frame: assert property (rd_alarm |=> reg_rdata_o[31:22] == {8'h00, TYPE_ALARM} && reg_rdata_o[3:0] == 4'h0)
    else $error("alarm word frame wrong");
  a_chan_temp_only: assert property (rd_chan |=> (reg_rdata_o & 32'hFFFFFF9F) == 32'h0)
    else $error("channel word has bits beyond temperature");
  a_cmp_follows_pins: assert property ($stable(pins)[*3] ##0 (warm > 4'h8 && rd_cmp) |=>
    reg_rdata_o[21:14] == cmp_pack($past(cmp_low_pin_i), $past(cmp_high_pin_i)))
    else $error("comparator flags differ from pins");
  a_alarm_live_latched: assert property ($stable({pins, clamp_fault_pin_i})[*3] ##0 (warm > 4'h8 && rd_alarm) |=>
    (reg_rdata_o[23:0] & 24'h155550) == live_pack($past(overtemp_pin_i), $past(guard_fault_pin_i),
    $past(clamp_fault_pin_i)) && (reg_rdata_o[23:0] & ~(reg_rdata_o[23:0] >> 1) & 24'h155550) == 24'h0)
    else $error("alarm live or latched flags wrong");
  a_fault_pin_drive: assert property ((warm > 4'h8 && (|{guard_fault_pin_i, clamp_fault_pin_i}))[*5] |->
    shared_fault_pin_oe_o && !shared_fault_pin_o)
    else $error("shared fault pin not pulled low");
  a_ot_pin_drive: assert property ((warm > 4'h8 && overtemp_pin_i)[*5] |-> overtemp_pin_oe_o && !overtemp_pin_o)
    else $error("overtemperature pin not pulled low");
  a_irq_mask_off: assert property (mask_copy == 9'h000 |-> !irq_o)
    else $error("interrupt raised with all sources masked");
  a_dac_select_echo: assert property (rd_dac |=> reg_rdata_o[23:16] == $past(sel_copy))
    else $error("converter word type or address wrong");
  c_irq_raised: cover property ($rose(irq_o));
  c_ot_cleared: cover property (rd_alarm ##1 !reg_rdata_o[21]);
  c_gain_read: cover property (rd_dac ##1 reg_rdata_o[23:22] == TYPE_GAIN);
endmodule

bind status_and_dac_readback readback_properties #(.ADDR_W(ADDR_W)) i_props (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cmp_low_pin_i(cmp_low_pin_i),
  .cmp_high_pin_i(cmp_high_pin_i), .overtemp_pin_i(overtemp_pin_i), .guard_fault_pin_i(guard_fault_pin_i),
  .clamp_fault_pin_i(clamp_fault_pin_i), .shared_fault_pin_o(shared_fault_pin_o),
  .shared_fault_pin_oe_o(shared_fault_pin_oe_o), .overtemp_pin_o(overtemp_pin_o),
  .overtemp_pin_oe_o(overtemp_pin_oe_o), .irq_o(irq_o));

//--- reg_host_model.sv
// Host model that drives the register port
`timescale 1ns/1ps
module reg_host_model (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic [7:0] reg_addr_o,
  output logic [31:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [31:0] reg_rdata_i
);
  initial begin
    reg_addr_o = 8'hFF;
    reg_wdata_o = 32'h0;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // Released lines are scrambled so a stale value is never mistaken for a live one
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk_i);
    reg_addr_o <= addr;
    reg_wdata_o <= data;
    reg_wr_o <= 1'b1;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~data;
    reg_addr_o <= ~addr;
  endtask
  task automatic rd(input logic [7:0] addr, output logic [31:0] data);
    @(posedge clk_i);
    reg_addr_o <= addr;
    reg_rd_o <= 1'b1;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~addr;
    #1;
    data = reg_rdata_i;
  endtask
endmodule

//--- status_and_dac_readback_tb.sv
// Self-checking bench for the status and converter readback block
`timescale 1ns/1ps
module status_and_dac_readback_tb
  import readback_pkg::*;
;
  logic clk_i;
  logic rst_b_i;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wr;
  logic rd;
  logic [3:0] cmp_lo;
  logic [3:0] cmp_hi;
  logic [3:0] guard;
  logic [3:0] clamp;
  logic ot_pin;
  logic shared_o;
  logic shared_oe;
  logic ot_o;
  logic ot_oe;
  logic irq;
  int n_fail = 0;
  int comparisons = 0;

  status_and_dac_readback i_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .cmp_low_pin_i(cmp_lo), .cmp_high_pin_i(cmp_hi),
    .overtemp_pin_i(ot_pin), .guard_fault_pin_i(guard), .clamp_fault_pin_i(clamp),
    .shared_fault_pin_o(shared_o), .shared_fault_pin_oe_o(shared_oe), .overtemp_pin_o(ot_o),
    .overtemp_pin_oe_o(ot_oe), .irq_o(irq));
  reg_host_model i_host (
    .clk_i(clk_i), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_rdata_i(rdata));

  // ==========================================================================
  // Tasks
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic expect_rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    i_host.rd(a, d);
    check(d, exp);
  endtask
  // Four edges cover the pin synchroniser, the latch and the status update
  task automatic set_pins(input logic [3:0] lo, input logic [3:0] hi, input logic ot, input logic [3:0] g,
    input logic [3:0] k);
    @(posedge clk_i);
    cmp_lo <= lo;
    cmp_hi <= hi;
    ot_pin <= ot;
    guard <= g;
    clamp <= k;
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  // ==========================================================================
  // Clock, watchdog and sequence
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    logic [7:0] f;
    logic [15:0] d;
    rst_b_i = 1'b0;
    {cmp_lo, cmp_hi} = 8'h00;
    {ot_pin, guard, clamp} = 9'h1FF;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    expect_rd(OFS_CMP_WORD, 32'h400000);
    expect_rd(OFS_ALARM_WORD, 32'hFFFFF0);
    for (int k = 0; k < 4; k++) begin
      expect_rd(OFS_CHAN_WORD0 + 8'(4 * k), 32'h60);
    end
    expect_rd(OFS_DAC_SELECT, 32'hC00000);
    expect_rd(8'h40, 32'h0);
    $display("test reset values done");
    for (int k = 0; k < 8; k++) begin
      f = 8'h80 >> k;
      set_pins({f[1], f[3], f[5], f[7]}, {f[0], f[2], f[4], f[6]}, 1'b1, 4'hF, 4'hF);
      i_host.wr(OFS_CMP_WORD, 32'hFFFFFF);
      expect_rd(OFS_CMP_WORD, {8'h00, TYPE_CMP, f, 14'h0});
    end
    $display("test comparator word done");
    set_pins(4'h0, 4'h0, 1'b0, 4'h0, 4'h0);
    expect_rd(OFS_ALARM_WORD, 32'hEAAAA0);
    i_host.wr(OFS_MEAS_CTRL, 32'h40);
    expect_rd(OFS_ALARM_WORD, 32'hCAAAA0);
    expect_rd(OFS_CHAN_WORD0 + 8'h08, 32'h0);
    i_host.wr(OFS_MEAS_CTRL, 32'h20);
    expect_rd(OFS_ALARM_WORD, 32'hC00000);
    check({30'h0, shared_oe, ot_oe}, 32'h0);
    set_pins(4'h0, 4'h0, 1'b1, 4'h2, 4'h4);
    i_host.wr(OFS_MEAS_CTRL, 32'h60);
    expect_rd(OFS_ALARM_WORD, 32'hF300C0);
    expect_rd(OFS_CHAN_WORD0 + 8'h0C, 32'h60);
    check({30'h0, shared_oe, ot_oe}, 32'h3);
    set_pins(4'h0, 4'h0, 1'b0, 4'h0, 4'h0);
    i_host.wr(OFS_ALARM_WORD, 32'h0);
    expect_rd(OFS_ALARM_WORD, 32'hE20080);
    $display("test alarm word done");
    check({31'h0, irq}, 32'h0);
    expect_rd(OFS_IRQ_STATUS, 32'h85);
    expect_rd(OFS_IRQ_STATUS, 32'h0);
    i_host.wr(OFS_IRQ_MASK, 32'h1FF);
    set_pins(4'h0, 4'h0, 1'b0, 4'h8, 4'h0);
    check({31'h0, irq}, 32'h1);
    expect_rd(OFS_IRQ_STATUS, 32'h10);
    check({31'h0, irq}, 32'h0);
    i_host.wr(OFS_IRQ_MASK, 32'h1EF);
    expect_rd(OFS_IRQ_MASK, 32'h1EF);
    set_pins(4'h0, 4'h0, 1'b0, 4'h0, 4'h0);
    set_pins(4'h0, 4'h0, 1'b0, 4'h8, 4'h0);
    check({31'h0, irq}, 32'h0);
    expect_rd(OFS_IRQ_STATUS, 32'h10);
    $display("test interrupt done");
    for (int t = 1; t < 4; t++) begin
      d = (t == 1) ? GAIN_RESET : (t == 2) ? OFFSET_RESET : CODE_RESET;
      i_host.wr(OFS_DAC_SELECT, {8'h00, t[1:0], 6'h3F, 16'h0});
      expect_rd(OFS_DAC_SELECT, {8'h00, t[1:0], 6'h3F, d});
      d = 16'hA5C3 ^ 16'(t);
      i_host.wr(OFS_DAC_WRITE, {8'h00, t[1:0], 6'h3F, d});
      expect_rd(OFS_DAC_SELECT, {8'h00, t[1:0], 6'h3F, d});
    end
    i_host.wr(OFS_DAC_WRITE, {8'h00, 2'h0, 6'h3F, 16'h1111});
    expect_rd(OFS_DAC_SELECT, {8'h00, TYPE_CODE, 6'h3F, d});
    i_host.wr(OFS_DAC_SELECT, {8'h00, 2'h0, 6'h15, 16'h0});
    expect_rd(OFS_DAC_SELECT, {8'h00, 2'h0, 6'h15, 16'h0});
    $display("test converter readback done");
    report_and_stop;
  end
endmodule
